// >>> hw/oas_pkg.sv
// Behaviour
// RL1 - nonzero increment result discards fetched word
// RL2 - increment file, write to acc or file
// RL3 - two-word skipped instruction: two idle cycles
// RL4 - three-word skipped instruction: three idle cycles
// RL5 - literal-OR decoded by 0000 1001 kkkk kkkk
// RL6 - literal-OR result goes into accumulator
// RL7 - acc-OR-file decoded by 0001 00da ffff ffff
// RL8 - destination bit picks accumulator or file
// RL9 - bank bit picks access bank or pointer
// RL10 - extended set, access bank, f<=95 indexed
// RL11 - OR updates N and Z in one cycle
package oas_pkg;

   localparam logic [7:0] OPC_OR_LIT    = 8'h09;
   localparam logic [5:0] OPC_OR_FILE   = 6'h04;
   localparam logic [5:0] OPC_INC_SKIP  = 6'h12;
   localparam int         POS_DEST      = 9;
   localparam int         POS_BANK      = 8;
   localparam logic [7:0] INDEXED_LIMIT = 8'h5F;
   localparam logic [7:0] ACCESS_SPLIT  = 8'h60;
   localparam logic [3:0] BANK_ACCESS_HI = 4'hF;
   localparam logic [7:0] ACC_RESET     = 8'h00;
   localparam logic [1:0] IDLE_NONE     = 2'h0;
   localparam logic [1:0] IDLE_ONE      = 2'h1;

   // four phases of one instruction cycle, gray coded
   typedef enum logic [1:0]
   {
      OAS_Q1 = 2'b00,
      OAS_Q2 = 2'b01,
      OAS_Q3 = 2'b11,
      OAS_Q4 = 2'b10
   } oas_phase_type;

   typedef enum logic [1:0]
   {
      OAS_OP_NONE = 2'h0,
      OAS_OP_LIT  = 2'h1,
      OAS_OP_FILE = 2'h2,
      OAS_OP_INC  = 2'h3
   } oas_op_type;

   // data memory access request toward the file array
   typedef struct packed
   {
      logic        rd;
      logic        wr;
      logic        indexed;
      logic [11:0] addr;
      logic [7:0]  wdata;
   } oas_mem_type;

endpackage : oas_pkg

// >>> hw/oas_core.sv
`timescale 1ns/1ns
module oas_core
(
   input  wire logic               clk,
   input  wire logic               rst_n,
   input  wire logic [15:0]        instr,
   input  wire logic               instr_valid,
   input  wire logic [1:0]         next_words,
   input  wire logic               ext_set_en,
   input  wire logic [5:0]         bank_select_pointer,
   input  wire logic [7:0]         file_rdata,
   output oas_pkg::oas_mem_type    mem,
   output logic [7:0]              acc,
   output logic                    flag_n,
   output logic                    flag_z,
   output oas_pkg::oas_phase_type  phase,
   output logic                    idle,
   output logic                    instr_take
);

   ////////////////////////////////////////////////////////////////////////////
   // decode helpers

   function automatic oas_pkg::oas_op_type decode_op(input logic [15:0] w);
      if (w[15:8] == oas_pkg::OPC_OR_LIT)
         return oas_pkg::OAS_OP_LIT; // RL5
      else if (w[15:10] == oas_pkg::OPC_OR_FILE)
         return oas_pkg::OAS_OP_FILE; // RL7
      else if (w[15:10] == oas_pkg::OPC_INC_SKIP)
         return oas_pkg::OAS_OP_INC;
      else
         return oas_pkg::OAS_OP_NONE;
   endfunction : decode_op

   // bank bit low: access bank split low/high; high: bank pointer
   function automatic logic [11:0] file_addr(input logic a, input logic [7:0] f,
                                             input logic [5:0] bsp);
      if (a)
         return {bsp[3:0], f}; // RL9
      else if (f < oas_pkg::ACCESS_SPLIT)
         return {4'h0, f}; // RL9
      else
         return {oas_pkg::BANK_ACCESS_HI, f}; // RL9
   endfunction : file_addr

   // operations that read a file register and may write it back
   function automatic logic uses_file(input oas_pkg::oas_op_type o);
      return (o == oas_pkg::OAS_OP_FILE) || (o == oas_pkg::OAS_OP_INC);
   endfunction : uses_file

   // operations that post n and z; increment-skip leaves status alone
   function automatic logic sets_flags(input oas_pkg::oas_op_type o);
      return (o == oas_pkg::OAS_OP_LIT) || (o == oas_pkg::OAS_OP_FILE); // RL11
   endfunction : sets_flags

   // the literal form always lands in acc, since its bit 9 is opcode, not a
   // destination; file forms follow the destination bit
   function automatic logic writes_acc(input oas_pkg::oas_op_type o, input logic d);
      if (o == oas_pkg::OAS_OP_LIT)
         return 1'b1; // RL6
      else if (o == oas_pkg::OAS_OP_NONE)
         return 1'b0;
      else
         return !d; // RL8 RL2
   endfunction : writes_acc

   ////////////////////////////////////////////////////////////////////////////
   // instruction register and phase counter

   logic [15:0]           ir;
   oas_pkg::oas_op_type   op;
   logic [1:0]            idle_left;
   logic [7:0]            operand;
   logic [7:0]            result;
   logic                  dest_file;
   logic                  skip;

   assign op         = decode_op(ir);
   assign dest_file  = ir[oas_pkg::POS_DEST];
   // idle stands for whole cycles, so all four phases of a skipped cycle are quiet
   assign idle       = idle_left != oas_pkg::IDLE_NONE; // RL3
   // a new word is only taken at the start of a non-idle cycle; during idle
   // the fetch side keeps presenting its word and it is simply not latched
   assign instr_take = (phase == oas_pkg::OAS_Q1) && !idle;

   // phases cycle Q1..Q4 endlessly
   // gray order: one bit moves per phase, so phase decodes never glitch
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         phase <= oas_pkg::OAS_Q1;
      else
         case (phase)
            oas_pkg::OAS_Q1: phase <= oas_pkg::OAS_Q2;
            oas_pkg::OAS_Q2: phase <= oas_pkg::OAS_Q3;
            oas_pkg::OAS_Q3: phase <= oas_pkg::OAS_Q4;
            default:         phase <= oas_pkg::OAS_Q1;
         endcase
   end

   // q1 decode: latch word; an idle cycle latches nothing
   // clearing ir at the q1 edge of an idle cycle keeps a stale opcode from
   // running a second time with the next cycle's operands
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         ir <= 16'h0000;
      else if (instr_take)
         ir <= instr_valid ? instr : 16'h0000;
      else if (phase == oas_pkg::OAS_Q1)
         ir <= 16'h0000; // discarded word becomes a no-op
   end

   ////////////////////////////////////////////////////////////////////////////
   // datapath: q2 read, q3 process, q4 write
   // cycle timing, one instruction per four clocks:
   //   q1 edge  word latched into ir, or cleared when idle
   //   q2       read strobe up, operand captured at its edge
   //   q3       result formed from operand and accumulator
   //   q4       write strobe up; acc, flags and skip count move at its edge
   // results are therefore visible from q1 of the following cycle

   // q2 operand read, literal or file
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         operand <= 8'h00;
      else if (phase == oas_pkg::OAS_Q2)
      begin
         if (op == oas_pkg::OAS_OP_LIT)
            operand <= ir[7:0]; // RL5
         else
            operand <= file_rdata;
      end
   end

   // q3 process
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         result <= 8'h00;
      else if (phase == oas_pkg::OAS_Q3)
      begin
         // the sum wraps at eight bits; a wrap to zero is what suppresses the skip
         if (op == oas_pkg::OAS_OP_INC)
            result <= 8'(operand + 8'h01); // RL2
         else
            result <= acc | operand; // RL6
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // skip decision

   // judged on the registered sum, which stands through all of q4; it is
   // sampled only at the q4 edge, so idle starts with the next cycle
   assign skip = (op == oas_pkg::OAS_OP_INC) && (result != 8'h00); // RL1

   // q2 read request and q4 write request toward the file array
   always_comb
   begin
      mem         = '0;
      // the address is shown in every phase so the array has it set up early
      mem.addr    = file_addr(ir[oas_pkg::POS_BANK], ir[7:0], bank_select_pointer);
      mem.wdata   = result;
      // strobes and mode only for operations that really touch a file
      if (uses_file(op))
      begin
         mem.rd      = phase == oas_pkg::OAS_Q2;
         mem.wr      = (phase == oas_pkg::OAS_Q4) && dest_file; // RL8 RL2
         // indexed offset mode is only flagged; the offset add lives in the
         // address unit, which limits this block to the flag
         mem.indexed = ext_set_en && !ir[oas_pkg::POS_BANK]
                       && (ir[7:0] <= oas_pkg::INDEXED_LIMIT); // RL10
      end
   end

   // q4 accumulator write
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         acc <= oas_pkg::ACC_RESET;
      else if ((phase == oas_pkg::OAS_Q4) && writes_acc(op, dest_file))
         acc <= result; // RL6 RL8 RL2
   end

   // q4 flags, OR instructions only; increment-skip leaves them alone
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         flag_n <= 1'b0;
         flag_z <= 1'b0;
      end
      else if ((phase == oas_pkg::OAS_Q4) && sets_flags(op))
      begin
         flag_n <= result[7]; // RL11
         flag_z <= result == 8'h00; // RL11
      end
   end

   // skip: one idle cycle per word of the fetched next instruction
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         idle_left <= oas_pkg::IDLE_NONE;
      else if (phase == oas_pkg::OAS_Q4)
      begin
         if (skip)
         begin
            // a count of zero is read as one, so a taken skip is never silent
            if (next_words == oas_pkg::IDLE_NONE)
               idle_left <= oas_pkg::IDLE_ONE; // RL1
            else
               idle_left <= next_words; // RL3 RL4
         end
         else if (idle)
         begin
            // counts down at the end of each idle cycle and stops at zero
            idle_left <= 2'(idle_left - oas_pkg::IDLE_ONE);
         end
      end
   end

endmodule : oas_core

// >>> bench/oas_core_props.sv
`timescale 1ns/1ns
module oas_props
(
   input logic                   clk,
   input logic                   rst_n,
   input logic [15:0]            instr,
   input logic                   instr_valid,
   input logic                   ext_set_en,
   input logic [5:0]             bank_select_pointer,
   input oas_pkg::oas_mem_type   mem,
   input logic [7:0]             acc,
   input logic                   flag_n,
   input logic                   flag_z,
   input oas_pkg::oas_phase_type phase,
   input logic                   idle,
   input logic                   instr_take
);
default clocking @(posedge clk); endclocking
default disable iff (!rst_n);
// accepted words by opcode; a dropped valid is a no-op
wire t = instr_take && instr_valid;
wire lit = t && instr[15:8] == 8'h09;
wire fil = t && instr[15:10] == 6'h04;
////////////////////////////////////////////////////////////////////////////////
take_in_q1_a: assert property
   (instr_take |-> phase == 2'h0 && !idle) else $error("bad take");
phase_walk_a: assert property
   (phase == 2'h0 |=> phase == 2'h1 ##1 phase == 2'h3 ##1 phase == 2'h2) else $error("bad phase");
read_in_q2_a: assert property
   (mem.rd |-> phase == 2'h1 && !idle) else $error("bad read");
write_in_q4_a: assert property
   (mem.wr |-> phase == 2'h2 && !idle) else $error("bad write");
lit_or_a: assert property
   (lit |-> ##4 acc == ($past(acc, 4) | $past(instr[7:0], 4))) else $error("bad or");
lit_flags_a: assert property
   (lit |-> ##4 flag_n == ($past(acc[7], 4) | $past(instr[7], 4))
      && flag_z == (acc == 8'h00)) else $error("bad flags");
bank_sel_a: assert property
   (fil && instr[8] |=> mem.rd && mem.addr ==
      {$past(bank_select_pointer[3:0]), $past(instr[7:0])}) else $error("bad bank");
indexed_flag_a: assert property
   (fil && !instr[8] |=> mem.indexed ==
      ($past(ext_set_en) && $past(instr[7:0]) <= 8'h5F)) else $error("bad index");
idle_quiet_a: assert property
   (idle |=> $stable(acc) && $stable(flag_n) && $stable(flag_z)) else $error("busy idle");
endmodule : oas_props
bind oas_core oas_props oas_props_inst (.clk, .rst_n, .instr, .instr_valid, .ext_set_en,
   .bank_select_pointer, .mem, .acc, .flag_n, .flag_z, .phase, .idle, .instr_take);

// >>> bench/oas_core_tb_top.sv
`timescale 1ns/1ns
module oas_core_tb_top;
logic                   clk = 1'b0;
logic                   rst_n = 1'b0;
logic                   instr_valid = 1'b0;
logic                   ext_set_en = 1'b0;
logic [15:0]            instr = 16'h0000;
logic [1:0]             next_words = 2'h1;
logic [5:0]             bank_select_pointer = 6'h25;
logic [7:0]             file_rdata = 8'h00;
oas_pkg::oas_mem_type   mem, rq, wq;
oas_pkg::oas_phase_type phase;
logic [7:0]             acc;
logic                   flag_n, flag_z, idle, instr_take;
int                     err_total = 0;
int                     num_checks = 0;
int                     k;
oas_core oas_core_inst (.clk, .rst_n, .instr, .instr_valid, .next_words, .ext_set_en,
   .bank_select_pointer, .file_rdata, .mem, .acc, .flag_n, .flag_z, .phase, .idle, .instr_take);
////////////////////////////////////////////////////////////////////////////////
task automatic chk(input logic [31:0] g, input logic [31:0] e);
   num_checks++;
   if (g !== e)
   begin
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
      err_total++;
   end
endtask : chk
// one word; valid drops at the take edge so the word never runs twice
task automatic go(input logic [15:0] w, input logic [7:0] r, input logic [1:0] n);
   @(posedge clk);
   instr <= w;
   instr_valid <= 1'b1;
   file_rdata <= r;
   next_words <= n;
   // take is combinational from phase: look at it only off the edge
   k = 0;
   @(negedge clk);
   while (!instr_take && k < 40)
   begin
      @(negedge clk);
      k++;
   end
   if (k == 40) report_and_stop(1);
   @(posedge clk);
   instr_valid <= 1'b0;
   @(negedge clk);
   rq = mem;
   repeat (2) @(negedge clk);
   wq = mem;
   @(negedge clk);
endtask : go
task automatic t_skip(input logic [1:0] n, input logic [7:0] r);
   go(16'h4800, r, n);
   chk(acc, 8'(r + 8'h01));
   for (k = 0; k < 20 && idle; k++) @(negedge clk);
   chk(k, (r == 8'hFF) ? 0 : ((n == 2'h0) ? 4 : n * 4));
   if (k == 20) report_and_stop(1);
   $display("skip test done");
endtask : t_skip
task automatic t_or;
   go(16'h0900, 8'h00, 2'h1);
   chk({flag_n, flag_z, acc}, 10'h100);
   go(16'h099A, 8'h00, 2'h1);
   go(16'h0935, 8'h00, 2'h1);
   chk({flag_n, flag_z, acc}, 10'h2BF);
   go(16'h0A40, 8'h00, 2'h1);
   chk(acc, 8'hBF);
   go(16'h1280, 8'h40, 2'h1);
   chk({wq.wr, wq.addr, wq.wdata, acc}, 29'h1F80FFBF);
   go(16'h1134, 8'h40, 2'h1);
   chk({rq.rd, rq.addr, flag_n, flag_z, acc}, 23'h54D2FF);
   @(posedge clk);
   ext_set_en <= 1'b1;
   go(16'h105F, 8'h00, 2'h1);
   chk(rq.indexed, 1'b1);
   go(16'h1060, 8'h00, 2'h1);
   chk(rq.indexed, 1'b0);
   $display("or test done");
endtask : t_or
task automatic t_inc_file;
   go(16'h4A10, 8'h2F, 2'h1);
   chk({wq.wr, wq.addr, wq.wdata}, 21'h101030);
   chk(acc, 8'hFF);
   $display("increment to file test done");
endtask : t_inc_file
task automatic report_and_stop(input int e);
   err_total += e;
   $display("checks %0d mismatches %0d", num_checks, err_total);
   if (err_total == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
   else
      $display("CHECKS NOT OK");
   $finish;
endtask : report_and_stop
////////////////////////////////////////////////////////////////////////////////
initial
begin
   forever #10 clk = ~clk;
end
initial
begin
   repeat (6) @(posedge clk);
   rst_n <= 1'b1;
   t_or();
   t_inc_file();
   t_skip(2'h1, 8'h05);
   t_skip(2'h0, 8'h20);
   t_skip(2'h2, 8'h07);
   t_skip(2'h3, 8'h10);
   t_skip(2'h3, 8'hFF);
   report_and_stop(0);
end
endmodule : oas_core_tb_top
